// File: hw/pps_defines.vh
/*
 * Constants for the per-port status page: register indices, field positions,
 * reset values, line and speed codes and timing counts.
 * Assumes inclusion by its bare name from the port status page design file.
 */
`ifndef PPS_DEFINES_VH
`define PPS_DEFINES_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define PPS_NPORTS 3
`define PPS_SEL_W 4
`define PPS_ADDR_W 4

// ----------------------------------------------------------------
// Register indices (byte-wide registers)
// ----------------------------------------------------------------
`define PPS_REG_STAT0 4'h0
`define PPS_REG_STAT1 4'h1
`define PPS_REG_STAT2 4'h2
`define PPS_REG_SELECT 4'h7

// ----------------------------------------------------------------
// Field positions, bit 7 is the most significant bit of the byte
// ----------------------------------------------------------------
`define PPS_B0_A_HI 7
`define PPS_B0_A_LO 6
`define PPS_B0_B_HI 5
`define PPS_B0_B_LO 4
`define PPS_B0_CHILD 3
`define PPS_B0_CON 2
`define PPS_B0_RECEIVE_VALID_FLAG 1
`define PPS_B0_DIS 0
`define PPS_B1_SPD_HI 7
`define PPS_B1_SPD_LO 5
`define PPS_B1_PIE 4
`define PPS_B1_FAULT 3
`define PPS_B1_SBY 2
`define PPS_B1_SCRM 1
`define PPS_B1_HSONLY 0
`define PPS_B2_DC 7
`define PPS_SEL_HI 3
`define PPS_SEL_LO 0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define PPS_RST_BIT 1'b0
`define PPS_RST_SEL 4'h0
`define PPS_HSONLY_VAL 1'b0
`define PPS_LINE_Z 2'h3
`define PPS_LINE_ONE 2'h1
`define PPS_LINE_ZERO 2'h2
`define PPS_LINE_INVALID 2'h0
`define PPS_SPD_S100 3'h0
`define PPS_SPD_S200 3'h1
`define PPS_SPD_S400 3'h2
`define PPS_SPD_S800 3'h3
`define PPS_SPD_S1600 3'h4
`define PPS_SPD_S3200 3'h5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPS_CLK_MHZ 100
`define PPS_DEBOUNCE_MS 341
`define PPS_DEBOUNCE_CYC (`PPS_DEBOUNCE_MS * 1000 * `PPS_CLK_MHZ)

`endif

// File: hw/pps_port_status.v
/*
 * Per-port status and control page of a three-port cable PHY: line state,
 * role, debounced connection, receive valid, negotiated speed, fault flags
 * and per-port control bits, reached over a simple byte register port.
 * Assumes the per-port line, bias and event inputs come from cable logic
 * outside the core clock domain; all are synchronised here.
 */
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "pps_defines.vh"

module pps_port_status #(
    parameter DEBOUNCE_CYC = `PPS_DEBOUNCE_CYC
) (
    // Clock, reset, enable
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    input wire i_bus_reset,
    // Register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // Per-port cable status, one slice per port
    input wire [5:0] i_cable_pair_a,
    input wire [5:0] i_cable_pair_b,
    input wire [2:0] i_port_child,
    input wire [2:0] i_port_attached,
    input wire [2:0] i_port_suspended,
    input wire [2:0] i_high_speed,
    input wire [2:0] i_tones_seen,
    input wire [2:0] i_speed_done,
    input wire [2:0] i_cable_bias,
    input wire [2:0] i_signal_valid,
    input wire [8:0] i_hs_speed,
    input wire [8:0] i_selfid_speed,
    input wire [2:0] i_resuming,
    input wire [2:0] i_suspending,
    input wire [2:0] i_in_standby,
    input wire [2:0] i_standby_err,
    input wire [2:0] i_remote_sby_clr,
    input wire [2:0] i_dc_detect,
    // Per-port controls and link notification
    output wire [2:0] o_port_disable,
    output wire [2:0] o_port_may_activate,
    output wire [2:0] o_scrambler_off,
    output wire [2:0] o_standby_err_clr,
    output reg o_port_event_irq_flag
);

    localparam NP = `PPS_NPORTS;
    localparam IW = 42;

    // ----------------------------------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------------------------------
    reg [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    wire [IW-1:0] raw_in = {i_cable_pair_a, i_cable_pair_b, i_port_child, i_port_attached,
        i_port_suspended, i_high_speed, i_tones_seen, i_speed_done, i_cable_bias,
        i_signal_valid, i_resuming, i_suspending};
    reg [IW-1:0] in_m_q;
    reg [IW-1:0] in_s_q;
    reg [20:0] hs_spd_m_q;
    reg [20:0] hs_spd_s_q;
    reg [11:0] sby_m_q;
    reg [11:0] sby_s_q;
    // Cable inputs may change at any time; two flops cut metastability
    // at the price of two cycles of latency on every status bit
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_m_q <= {IW{1'b0}};
            in_s_q <= {IW{1'b0}};
            hs_spd_m_q <= 21'h0;
            hs_spd_s_q <= 21'h0;
            sby_m_q <= 12'h0;
            sby_s_q <= 12'h0;
        end else if (i_ce) begin
            in_m_q <= raw_in;
            in_s_q <= in_m_q;
            hs_spd_m_q <= {i_hs_speed, i_selfid_speed, i_dc_detect};
            hs_spd_s_q <= hs_spd_m_q;
            sby_m_q <= {i_in_standby, i_standby_err, i_remote_sby_clr, 3'h0};
            sby_s_q <= sby_m_q;
        end
    end

    // ----------------------------------------------------------------
    // Synchronised input slices
    // ----------------------------------------------------------------
    // Only the second flop of each chain is read below
    wire [5:0] pa = in_s_q[41:36];
    wire [5:0] pb = in_s_q[35:30];
    wire [2:0] child = in_s_q[29:27];
    wire [2:0] attached = in_s_q[26:24];
    wire [2:0] suspended = in_s_q[23:21];
    wire [2:0] hs_mode = in_s_q[20:18];
    wire [2:0] tones = in_s_q[17:15];
    wire [2:0] spd_done = in_s_q[14:12];
    wire [2:0] bias = in_s_q[11:9];
    wire [2:0] sig_ok = in_s_q[8:6];
    // Both fault sources are live: a resume needs bias, a suspend must lose it
    wire [2:0] resuming = in_s_q[5:3];
    wire [2:0] suspending = in_s_q[2:0];
    wire [8:0] hs_spd = hs_spd_s_q[20:12];
    wire [8:0] sid_spd = hs_spd_s_q[11:3];
    wire [2:0] dc_det = hs_spd_s_q[2:0];
    wire [2:0] in_sby = sby_s_q[11:9];
    wire [2:0] sby_err = sby_s_q[8:6];
    wire [2:0] remote_clr = sby_s_q[5:3];

    // ----------------------------------------------------------------
    // Per-port slice helpers
    // ----------------------------------------------------------------
    // Callers keep the port index below three; a higher one reads unknown
    function [2:0] pick3;
        input [8:0] vec;
        input [1:0] port;
        begin
            pick3 = vec[3*port +: 3];
        end
    endfunction

    function [1:0] pick2;
        input [5:0] vec;
        input [1:0] port;
        begin
            pick2 = vec[2*port +: 2];
        end
    endfunction

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    reg [3:0] sel_q;
    reg [NP-1:0] dis_q;
    reg [NP-1:0] pie_q;
    reg [NP-1:0] scrm_q;
    // A selector of three or more points at a port that does not exist
    wire sel_ok = (sel_q < NP);
    wire [1:0] sp = sel_q[1:0];
    wire wr0 = i_ce && i_wr && (i_addr == `PPS_REG_STAT0) && sel_ok;
    wire wr1 = i_ce && i_wr && (i_addr == `PPS_REG_STAT1) && sel_ok;

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= `PPS_RST_SEL;
            dis_q <= {NP{`PPS_RST_BIT}};
            pie_q <= {NP{`PPS_RST_BIT}};
            scrm_q <= {NP{`PPS_RST_BIT}};
        end else if (i_ce) begin
            // Only hardware reset touches these; bus reset leaves them alone
            if (i_wr && (i_addr == `PPS_REG_SELECT))
                sel_q <= i_wdata[`PPS_SEL_HI:`PPS_SEL_LO];
            if (wr0)
                dis_q[sp] <= i_wdata[`PPS_B0_DIS];
            if (wr1) begin
                pie_q[sp] <= i_wdata[`PPS_B1_PIE];
                scrm_q[sp] <= i_wdata[`PPS_B1_SCRM];
            end
        end
    end

    assign o_port_disable = dis_q;
    assign o_scrambler_off = scrm_q;

    // ----------------------------------------------------------------
    // Per-port status state
    // ----------------------------------------------------------------
    // Wide enough for the full debounce interval at the core rate
    reg [31:0] deb_q [0:NP-1];
    reg [NP-1:0] con_q;
    reg [NP-1:0] fault_q;
    reg [NP-1:0] sby_q;
    reg [NP-1:0] bias_prev_q;
    reg [NP-1:0] dis_prev_q;
    reg [8:0] spd_q;
    reg [NP-1:0] receive_valid_flag;
    reg [NP-1:0] conn_raw;
    reg [NP-1:0] fault_set;
    reg [NP-1:0] sby_clr;
    reg [NP-1:0] fault_clr;
    reg [NP-1:0] evt;
    integer k;

    always @* begin
        for (k = 0; k < NP; k = k + 1) begin
            // High-speed links count as connected only after tones and speed agreement
            conn_raw[k] = hs_mode[k] ? (tones[k] && spd_done[k]) : attached[k];
            // Tones alone never make the receiver valid in high-speed mode
            receive_valid_flag[k] = hs_mode[k] ? sig_ok[k] : bias[k];
            fault_set[k] = (resuming[k] && !bias[k]) || (suspending[k] && bias[k]);
            // A clear is a port event only when it really drops the bit
            fault_clr[k] = wr1 && (sp == k) && i_wdata[`PPS_B1_FAULT] && fault_q[k];
            sby_clr[k] = wr1 && (sp == k) && i_wdata[`PPS_B1_SBY];
            sby_clr[k] = sby_clr[k] || remote_clr[k];
            evt[k] = (con_q[k] != conn_raw[k] && deb_q[k] == DEBOUNCE_CYC - 1)
                || (bias_prev_q[k] != bias[k]) || (dis_prev_q[k] != dis_q[k])
                || (fault_set[k] && !fault_q[k])
                || (fault_clr[k] && !fault_set[k]);
        end
    end


    // ----------------------------------------------------------------
    // Port controls seen by the cable logic
    // ----------------------------------------------------------------
    assign o_port_may_activate = con_q & receive_valid_flag & ~dis_q;
    assign o_standby_err_clr = sby_clr;

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (k = 0; k < NP; k = k + 1)
                deb_q[k] <= 32'h0;
            con_q <= {NP{`PPS_RST_BIT}};
            fault_q <= {NP{`PPS_RST_BIT}};
            sby_q <= {NP{`PPS_RST_BIT}};
            bias_prev_q <= {NP{1'b0}};
            dis_prev_q <= {NP{1'b0}};
            spd_q <= 9'h0;
            o_port_event_irq_flag <= 1'b0;
        end else if (i_ce) begin
            bias_prev_q <= bias;
            dis_prev_q <= dis_q;
            for (k = 0; k < NP; k = k + 1) begin
                // Connection flag only moves after the level held the whole interval
                if (con_q[k] == conn_raw[k])
                    deb_q[k] <= 32'h0;
                else if (deb_q[k] == DEBOUNCE_CYC - 1) begin
                    deb_q[k] <= 32'h0;
                    con_q[k] <= conn_raw[k];
                end else
                    deb_q[k] <= deb_q[k] + 32'h1;
                // Set wins over a write-one clear in the same cycle
                if (fault_set[k])
                    fault_q[k] <= 1'b1;
                else if (fault_clr[k])
                    fault_q[k] <= 1'b0;
                if (sby_err[k] && in_sby[k])
                    sby_q[k] <= 1'b1;
                else if (!in_sby[k] || sby_clr[k])
                    sby_q[k] <= 1'b0;
                // Legacy speed tracks the self-identification result continuously
                if (hs_mode[k] && tones[k] && spd_done[k])
                    spd_q[3*k +: 3] <= pick3(hs_spd, k[1:0]);
                else if (!hs_mode[k])
                    spd_q[3*k +: 3] <= pick3(sid_spd, k[1:0]);
            end
            // Flag self-clears only when no enabled event is pending
            o_port_event_irq_flag <= |(evt & pie_q);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    function [1:0] line_code;
        input [1:0] raw;
        begin
            line_code = raw;
        end
    endfunction

    reg [7:0] rd_d;
    reg is_child;
    always @* begin
        rd_d = 8'h0;
        // A non-participating port always looks like a child
        is_child = child[sp] || !con_q[sp] || dis_q[sp] || suspended[sp];
        if (sel_ok) begin
            case (i_addr)
                `PPS_REG_STAT0: begin
                    rd_d[`PPS_B0_A_HI:`PPS_B0_A_LO] = line_code(pick2(pa, sp));
                    rd_d[`PPS_B0_B_HI:`PPS_B0_B_LO] = line_code(pick2(pb, sp));
                    rd_d[`PPS_B0_CHILD] = is_child;
                    rd_d[`PPS_B0_CON] = con_q[sp];
                    rd_d[`PPS_B0_RECEIVE_VALID_FLAG] = receive_valid_flag[sp];
                    rd_d[`PPS_B0_DIS] = dis_q[sp];
                end
                `PPS_REG_STAT1: begin
                    rd_d[`PPS_B1_SPD_HI:`PPS_B1_SPD_LO] = pick3(spd_q, sp);
                    rd_d[`PPS_B1_PIE] = pie_q[sp];
                    rd_d[`PPS_B1_FAULT] = fault_q[sp];
                    rd_d[`PPS_B1_SBY] = sby_q[sp];
                    rd_d[`PPS_B1_SCRM] = scrm_q[sp];
                    rd_d[`PPS_B1_HSONLY] = `PPS_HSONLY_VAL;
                end
                `PPS_REG_STAT2: begin
                    rd_d[`PPS_B2_DC] = dc_det[sp];
                end
                default: begin
                    rd_d = 8'h0;
                end
            endcase
        end
        // The selector reads back even when it names an absent port
        if (i_addr == `PPS_REG_SELECT)
            rd_d = {4'h0, sel_q};
    end

    // Read data stand one cycle and are zero otherwise, so buses may be ORed
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n)
            o_rdata <= 8'h0;
        else if (i_ce)
            o_rdata <= i_rd ? rd_d : 8'h0;
    end

endmodule

// File: test/pps_port_status_sva.sv
/* Checker for the port status page, watching the top module ports only.
   Assumes a bind from the bench top and a 2-flop internal reset release. */
`timescale 1ns/100ps
module pps_port_status_sva (
    // Clock and control
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    input wire i_bus_reset,
    // Register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // Per-port controls
    input wire [2:0] o_port_disable,
    input wire [2:0] o_port_may_activate,
    input wire [2:0] o_scrambler_off,
    input wire [2:0] o_standby_err_clr
);
    // Shadow selector: tells which port a page write lands on
    reg [3:0] sel_q;
    wire wr_go = i_ce && i_wr;
    wire hit = sel_q < 4'h3;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            sel_q <= 4'h0;
        else if (wr_go && i_addr == 4'h7)
            sel_q <= i_wdata[3:0];
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_hs_only_zero: assert property ($past(i_ce && i_rd && i_addr == 4'h1) |-> !o_rdata[0])
        else $error("hs-only bit reads one");
    chk_dis_no_active: assert property ((o_port_disable & o_port_may_activate) == 3'h0)
        else $error("disabled port may activate");
    chk_oob_page_zero: assert property ($past(i_ce && i_rd && i_addr < 4'h3 && !hit) |-> o_rdata == 8'h0)
        else $error("absent port page not zero");
    chk_sel_read_back: assert property ($past(i_ce && i_rd && i_addr == 4'h7) |-> o_rdata[3:0] == $past(sel_q))
        else $error("selector readback wrong");
    chk_dis_write_lands: assert property (wr_go && i_addr == 4'h0 && hit |=> o_port_disable[$past(sel_q[1:0])] == $past(i_wdata[0]))
        else $error("disable write lost");
    chk_ctl_bus_reset: assert property (i_bus_reset && !wr_go |=> $stable(o_port_disable) && $stable(o_scrambler_off))
        else $error("bus reset altered controls");
    chk_scrm_write_lands: assert property (wr_go && i_addr == 4'h1 && hit |=> o_scrambler_off[$past(sel_q[1:0])] == $past(i_wdata[1]))
        else $error("scrambler write lost");
    chk_sby_clr_pulse: assert property (wr_go && i_addr == 4'h1 && hit && i_wdata[2] |-> o_standby_err_clr[sel_q[1:0]])
        else $error("standby clear missing");
endmodule

// File: test/pps_peer.sv
/* Peer port model for the three cable ports, purely combinational.
   Assumes the bench sets per-port link state at clock edges. */
`timescale 1ns/100ps
module pps_peer (
    // Link state set by the bench
    input wire [2:0] i_up,
    input wire [2:0] i_hs,
    input wire [2:0] i_done,
    input wire [1:0] i_line,
    input wire [2:0] i_spd,
    // Seen by the status page
    output wire [5:0] o_pair_a,
    output wire [5:0] o_pair_b,
    output wire [2:0] o_child,
    output wire [2:0] o_attached,
    output wire [2:0] o_high_speed,
    output wire [2:0] o_tones,
    output wire [2:0] o_speed_done,
    output wire [2:0] o_bias,
    output wire [2:0] o_signal_valid,
    output wire [8:0] o_spd,
    output wire [2:0] o_dc
);
    // Pair B differs from pair A so that swapped fields show up
    assign o_pair_a = {3{i_line}};
    assign o_pair_b = {3{~i_line}};
    // Port 1 faces the root, so it is the parent
    assign o_child = 3'h5;
    assign o_attached = i_up;
    assign o_high_speed = i_hs;
    assign o_tones = i_up & i_hs;
    assign o_speed_done = i_up & i_hs & i_done;
    // Bias drops as soon as the peer is unplugged
    assign o_bias = i_up & ~i_hs;
    assign o_signal_valid = i_up & i_hs & i_done;
    assign o_spd = {3{i_spd}};
    assign o_dc = i_up & ~i_hs;
endmodule

// File: test/pps_port_status_test.sv
/* Self-checking bench for the port status page.
   Assumes debounce shortened to 20 cycles and a 100 MHz clock. */
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module pps_port_status_test;
    localparam int DB = 20;
    reg i_clk = 1'b0;
    reg i_rst_n = 1'b0;
    reg i_bus_reset = 1'b0;
    reg [3:0] i_addr = 4'h0;
    reg [7:0] i_wdata = 8'h0;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg [2:0] up = 3'h0, hs = 3'h0, done = 3'h0, susp = 3'h0, resum = 3'h0;
    reg [2:0] sby = 3'h0, sby_err = 3'h0, rem_clr = 3'h0, spd = 3'h0;
    reg [1:0] line = 2'h3;
    reg [2:0] suspd = 3'h0;
    int irq_hits = 0;
    int irq_base = 0;
    wire [7:0] rdata;
    wire [2:0] dis, may, scr, sclr, ch, att, hsp, ton, sdn, bias, sv, dc;
    wire [5:0] pa, pb;
    wire [8:0] sp;
    wire irq;
    int bad_count = 0;
    int tests_run = 0;
    always #5 i_clk = ~i_clk;
    // Counts cycles in which the port event flag stands high
    always @(posedge i_clk) begin
        if (irq === 1'b1)
            irq_hits <= irq_hits + 1;
    end
    pps_peer i_peer (.i_up(up), .i_hs(hs), .i_done(done), .i_line(line), .i_spd(spd),
        .o_pair_a(pa), .o_pair_b(pb), .o_child(ch), .o_attached(att), .o_high_speed(hsp),
        .o_tones(ton), .o_speed_done(sdn), .o_bias(bias), .o_signal_valid(sv), .o_spd(sp),
        .o_dc(dc));
    pps_port_status #(.DEBOUNCE_CYC(DB)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_ce(1'b1), .i_bus_reset(i_bus_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_cable_pair_a(pa), .i_cable_pair_b(pb),
        .i_port_child(ch), .i_port_attached(att), .i_port_suspended(susp),
        .i_high_speed(hsp), .i_tones_seen(ton), .i_speed_done(sdn), .i_cable_bias(bias),
        .i_signal_valid(sv), .i_hs_speed(sp), .i_selfid_speed(sp), .i_resuming(resum),
        .i_suspending(suspd), .i_in_standby(sby), .i_standby_err(sby_err),
        .i_remote_sby_clr(rem_clr), .i_dc_detect(dc), .o_port_disable(dis),
        .o_port_may_activate(may), .o_scrambler_off(scr), .o_standby_err_clr(sclr),
        .o_port_event_irq_flag(irq));
    task cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task wr(input [3:0] a, input [7:0] v);
        begin
            i_addr <= a;
            i_wdata <= v;
            i_wr <= 1'b1;
            @(posedge i_clk);
            i_wr <= 1'b0;
            @(posedge i_clk);
        end
    endtask
    // Read data stand one cycle only, so they are judged inside it
    task rdc(input [3:0] a, input [7:0] m, input [7:0] e);
        begin
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_clk);
            i_rd <= 1'b0;
            #1;
            `CHK(rdata & m, e)
            @(posedge i_clk);
        end
    endtask
    task bus_rst;
        begin
            i_bus_reset <= 1'b1;
            cyc(2);
            i_bus_reset <= 1'b0;
        end
    endtask
    task stop_test;
        begin
            if (bad_count == 0 && tests_run > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_idle;
        begin
            rdc(4'h0, 8'hff, 8'hc8);
            rdc(4'h1, 8'h1f, 8'h00);
            wr(4'h0, 8'hfe);
            rdc(4'h0, 8'hff, 8'hc8);
            wr(4'h2, 8'hff);
            rdc(4'h2, 8'h80, 8'h00);
        end
    endtask
    task t_lines;
        for (int c = 0; c < 4; c++) begin
            line <= c[1:0];
            cyc(4);
            rdc(4'h0, 8'hf0, {c[1:0], ~c[1:0], 4'h0});
        end
    endtask
    task t_legacy;
        begin
            wr(4'h7, 8'h01);
            spd <= 3'h2;
            up <= 3'h2;
            cyc(DB / 2);
            rdc(4'h0, 8'h04, 8'h00);
            cyc(DB);
            // Role read only long after connection settles
            rdc(4'h0, 8'h0f, 8'h06);
            rdc(4'h1, 8'he0, 8'h40);
            rdc(4'h2, 8'h80, 8'h80);
            bus_rst;
            rdc(4'h0, 8'h04, 8'h04);
            susp <= 3'h2;
            cyc(4);
            rdc(4'h0, 8'h08, 8'h08);
            susp <= 3'h0;
        end
    endtask
    task t_hs;
        begin
            wr(4'h7, 8'h02);
            hs <= 3'h4;
            up <= 3'h6;
            cyc(DB + 10);
            rdc(4'h0, 8'h06, 8'h00);
            for (int s = 0; s < 6; s++) begin
                spd <= s[2:0];
                done <= 3'h4;
                cyc(DB + 10);
                rdc(4'h0, 8'h06, 8'h06);
                rdc(4'h1, 8'he0, {s[2:0], 5'h0});
                done <= 3'h0;
                cyc(DB + 10);
            end
        end
    endtask
    task t_dis;
        begin
            wr(4'h7, 8'h01);
            `CHK(may[1], 1'b1)
            wr(4'h0, 8'h01);
            rdc(4'h0, 8'h09, 8'h09);
            `CHK(may[1], 1'b0)
            bus_rst;
            rdc(4'h0, 8'h01, 8'h01);
            wr(4'h0, 8'h00);
            wr(4'h1, 8'h02);
            cyc(1);
            `CHK(may[1], 1'b1)
            `CHK(scr, 3'h2)
            wr(4'h1, 8'h00);
        end
    endtask
    task t_fault;
        begin
            wr(4'h7, 8'h00);
            wr(4'h1, 8'h10);
            irq_base = irq_hits;
            resum <= 3'h1;
            cyc(8);
            `CHK(irq_hits - irq_base, 1)
            `CHK(irq, 1'b0)
            resum <= 3'h0;
            cyc(3);
            rdc(4'h1, 8'h18, 8'h18);
            wr(4'h1, 8'h18);
            rdc(4'h1, 8'h18, 8'h10);
            wr(4'h1, 8'h00);
            // Suspending port 1 still sees bias; its events stay masked
            wr(4'h7, 8'h01);
            irq_base = irq_hits;
            suspd <= 3'h2;
            cyc(8);
            suspd <= 3'h0;
            cyc(3);
            `CHK(irq_hits - irq_base, 0)
            rdc(4'h1, 8'h08, 8'h08);
            wr(4'h1, 8'h08);
            rdc(4'h1, 8'h08, 8'h00);
            wr(4'h7, 8'h00);
        end
    endtask
    task t_sby;
        begin
            sby <= 3'h1;
            sby_err <= 3'h1;
            cyc(4);
            sby_err <= 3'h0;
            rdc(4'h1, 8'h04, 8'h04);
            wr(4'h1, 8'h04);
            rdc(4'h1, 8'h04, 8'h00);
            sby_err <= 3'h1;
            cyc(4);
            sby_err <= 3'h0;
            rdc(4'h1, 8'h04, 8'h04);
            rem_clr <= 3'h1;
            cyc(4);
            rem_clr <= 3'h0;
            rdc(4'h1, 8'h04, 8'h00);
            sby_err <= 3'h1;
            cyc(4);
            sby_err <= 3'h0;
            sby <= 3'h0;
            cyc(4);
            rdc(4'h1, 8'h04, 8'h00);
        end
    endtask
    task t_sel;
        begin
            wr(4'h7, 8'h03);
            rdc(4'h7, 8'h0f, 8'h03);
            rdc(4'h0, 8'hff, 8'h00);
            rdc(4'h1, 8'hff, 8'h00);
            rdc(4'h5, 8'hff, 8'h00);
            wr(4'h7, 8'h00);
        end
    endtask
    initial begin
        #100000;
        bad_count++;
        stop_test;
    end
    initial begin
        cyc(6);
        i_rst_n <= 1'b1;
        cyc(5);
        t_idle;
        t_lines;
        t_legacy;
        t_hs;
        t_dis;
        t_fault;
        t_sby;
        t_sel;
        stop_test;
    end
endmodule
bind pps_port_status pps_port_status_sva i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_bus_reset(i_bus_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_port_disable(o_port_disable),
    .o_port_may_activate(o_port_may_activate), .o_scrambler_off(o_scrambler_off),
    .o_standby_err_clr(o_standby_err_clr));
